// File: design/voice3_pkg.sv
// Constants for the voice-3, envelope-3 and filter register bank.
// Assumes an 8-bit data port and 16-bit byte addresses from the host.
package voice3_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;

   // Register byte addresses
   localparam logic [15:0] FREQ_LOW_ADDR     = 16'hd40e;
   localparam logic [15:0] FREQ_HIGH_ADDR    = 16'hd40f;
   localparam logic [15:0] PW_LOW_ADDR       = 16'hd410;
   localparam logic [15:0] PW_HIGH_ADDR      = 16'hd411;
   localparam logic [15:0] CONTROL_ADDR      = 16'hd412;
   localparam logic [15:0] ATTACK_DECAY_ADDR = 16'hd413;
   localparam logic [15:0] SUST_REL_ADDR     = 16'hd414;
   localparam logic [15:0] CUTOFF_LOW_ADDR   = 16'hd415;
   localparam logic [15:0] CUTOFF_HIGH_ADDR  = 16'hd416;
   localparam logic [15:0] RES_ROUTE_ADDR    = 16'hd417;
   localparam logic [15:0] MODE_VOL_ADDR     = 16'hd418;
   localparam logic [15:0] PADDLE_ONE_ADDR   = 16'hd419;
   localparam logic [15:0] PADDLE_TWO_ADDR   = 16'hd41a;
   localparam logic [15:0] OSC3_READ_ADDR    = 16'hd41b;
   localparam logic [15:0] ENV3_READ_ADDR    = 16'hd41c;

   // Control register bit positions
   localparam int CTL_NOISE_BIT = 7;
   localparam int CTL_PULSE_BIT = 6;
   localparam int CTL_SAW_BIT   = 5;
   localparam int CTL_TRI_BIT   = 4;
   localparam int CTL_TEST_BIT  = 3;
   localparam int CTL_RING_BIT  = 2;
   localparam int CTL_SYNC_BIT  = 1;
   localparam int CTL_GATE_BIT  = 0;

   // Mode/volume register bit positions
   localparam int MV_V3OFF_BIT = 7;
   localparam int MV_HP_BIT    = 6;
   localparam int MV_BP_BIT    = 5;
   localparam int MV_LP_BIT    = 4;

   // Reset values
   localparam logic [7:0]  REG_RESET  = 8'h00;
   localparam logic [22:0] LFSR_RESET = 23'h7fffff;

   // Cycles per envelope step for rate setting 0
   localparam int ENV_STEP_CYCLES = 16;

   typedef enum logic [2:0] {
      ENV_ATTACK  = 3'b001,
      ENV_DECAY   = 3'b010,
      ENV_RELEASE = 3'b100
   } env_state_type;

endpackage

// File: design/voice3_filter_regs.sv
// Register bank for voice 3, its envelope, the filter and master volume.
// Assumes a same-clock host port with one-cycle strobes and read data
// one cycle later; paddle and oscillator-2 inputs are on this clock.
`timescale 1ns/1ps

module voice3_filter_regs #(
   parameter int ENV_BASE = voice3_pkg::ENV_STEP_CYCLES
) (
   input  wire logic                           REF_CLK_I,
   input  wire logic                           RSTN_I,
   input  wire logic                           CE_I,
   input  wire logic [voice3_pkg::ADDR_W-1:0]  ADDR_I,
   input  wire logic [voice3_pkg::DATA_W-1:0]  WDATA_I,
   input  wire logic                           WR_I,
   input  wire logic                           RD_I,
   output logic      [voice3_pkg::DATA_W-1:0]  RDATA_O,
   input  wire logic [7:0]                     PADDLE1_I,
   input  wire logic [7:0]                     PADDLE2_I,
   input  wire logic                           OSC2_MSB_I,
   input  wire logic                           OSC2_WRAP_I,
   output logic      [15:0]                    FREQ_O,
   output logic      [11:0]                    PULSE_WIDTH_O,
   output logic      [3:0]                     WAVE_SEL_O,
   output logic                                GATE_O,
   output logic      [11:0]                    WAVE_O,
   output logic                                OSC3_MSB_O,
   output logic                                OSC3_WRAP_O,
   output logic      [7:0]                     ENV_LEVEL_O,
   output logic      [10:0]                    CUTOFF_O,
   output logic      [3:0]                     RESONANCE_O,
   output logic      [3:0]                     FILTER_ROUTE_O,
   output logic                                VOICE3_OFF_O,
   output logic      [2:0]                     FILTER_MODE_O,
   output logic      [3:0]                     VOLUME_O
);
   import voice3_pkg::*;

   if (ENV_BASE < 1 || ENV_BASE > 4095) begin : g_bad_base
      $error("ENV_BASE must be between 1 and 4095");
   end

   typedef struct packed {
      logic [15:0]   freq;
      logic [11:0]   pw;
      logic [7:0]    ctrl;
      logic [7:0]    ad;
      logic [7:0]    sr;
      logic [2:0]    cut_lo;
      logic [7:0]    cut_hi;
      logic [7:0]    res_rt;
      logic [7:0]    mode_vol;
      logic [7:0]    rdata;
      logic [23:0]   acc;
      logic          wrap;
      logic          clk19;
      logic [22:0]   lfsr;
      logic [11:0]   wave;
      env_state_type env;
      logic [7:0]    level;
      logic [15:0]   step_cnt;
      logic          gate_prev;
   } state_type;

   state_type s_q;
   state_type s_d;

   logic [11:0] tri_w;
   logic [11:0] saw_w;
   logic [11:0] pul_w;
   logic [11:0] noi_w;
   logic [11:0] mix_w;
   logic        tri_msb;
   logic [24:0] acc_sum;
   logic [3:0]  rate;
   logic [15:0] period;
   logic        step;
   logic [7:0]  sustain;

   // Waveform shapes from the current accumulator; noise from the noise register
   always_comb begin
      tri_msb = s_q.acc[23] ^ (s_q.ctrl[CTL_RING_BIT] & OSC2_MSB_I);
      tri_w   = tri_msb ? ~s_q.acc[22:11] : s_q.acc[22:11];
      saw_w   = s_q.acc[23:12];
      pul_w   = (s_q.acc[23:12] >= s_q.pw) ? 12'hfff : 12'h000;
      noi_w   = {s_q.lfsr[22], s_q.lfsr[20], s_q.lfsr[16], s_q.lfsr[13],
                 s_q.lfsr[11], s_q.lfsr[7], s_q.lfsr[4], s_q.lfsr[2],
                 4'h0};
      // Several selected shapes are ANDed; none selected gives zero
      mix_w = 12'hfff;
      if (s_q.ctrl[CTL_TRI_BIT]) begin
         mix_w = mix_w & tri_w;
      end
      if (s_q.ctrl[CTL_SAW_BIT]) begin
         mix_w = mix_w & saw_w;
      end
      if (s_q.ctrl[CTL_PULSE_BIT]) begin
         mix_w = mix_w & pul_w;
      end
      if (s_q.ctrl[CTL_NOISE_BIT]) begin
         mix_w = mix_w & noi_w;
      end
      if (s_q.ctrl[7:4] == 4'h0) begin
         mix_w = 12'h000;
      end
   end

   // Envelope step timing: longer period for higher rate settings
   always_comb begin
      unique case (s_q.env)
         ENV_ATTACK:  rate = s_q.ad[7:4];
         ENV_DECAY:   rate = s_q.ad[3:0];
         ENV_RELEASE: rate = s_q.sr[3:0];
         default:     rate = s_q.sr[3:0];
      endcase
      period  = 16'({12'h000, rate} + 16'h0001) * 16'(ENV_BASE);
      step    = (s_q.step_cnt + 16'h0001 >= period);
      sustain = {s_q.sr[7:4], s_q.sr[7:4]};
   end

   always_comb begin
      s_d = s_q;

      // Host writes; read-only addresses and unmapped ones are ignored
      if (WR_I) begin
         unique case (ADDR_I)
            FREQ_LOW_ADDR:     s_d.freq[7:0]  = WDATA_I;
            FREQ_HIGH_ADDR:    s_d.freq[15:8] = WDATA_I;
            PW_LOW_ADDR:       s_d.pw[7:0]    = WDATA_I;
            PW_HIGH_ADDR:      s_d.pw[11:8]   = WDATA_I[3:0];
            CONTROL_ADDR:      s_d.ctrl       = WDATA_I;
            ATTACK_DECAY_ADDR: s_d.ad         = WDATA_I;
            SUST_REL_ADDR:     s_d.sr         = WDATA_I;
            CUTOFF_LOW_ADDR:   s_d.cut_lo     = WDATA_I[2:0];
            CUTOFF_HIGH_ADDR:  s_d.cut_hi     = WDATA_I;
            RES_ROUTE_ADDR:    s_d.res_rt     = WDATA_I;
            MODE_VOL_ADDR:     s_d.mode_vol   = WDATA_I;
            default:           s_d.rdata      = s_q.rdata;
         endcase
      end

      // Read data stands only in the cycle after the strobe
      s_d.rdata = 8'h00;
      if (RD_I) begin
         unique case (ADDR_I)
            FREQ_LOW_ADDR:     s_d.rdata = s_q.freq[7:0];
            FREQ_HIGH_ADDR:    s_d.rdata = s_q.freq[15:8];
            PW_LOW_ADDR:       s_d.rdata = s_q.pw[7:0];
            PW_HIGH_ADDR:      s_d.rdata = {4'h0, s_q.pw[11:8]};
            CONTROL_ADDR:      s_d.rdata = s_q.ctrl;
            ATTACK_DECAY_ADDR: s_d.rdata = s_q.ad;
            SUST_REL_ADDR:     s_d.rdata = s_q.sr;
            CUTOFF_LOW_ADDR:   s_d.rdata = {5'h00, s_q.cut_lo};
            CUTOFF_HIGH_ADDR:  s_d.rdata = s_q.cut_hi;
            RES_ROUTE_ADDR:    s_d.rdata = s_q.res_rt;
            MODE_VOL_ADDR:     s_d.rdata = s_q.mode_vol;
            PADDLE_ONE_ADDR:   s_d.rdata = PADDLE1_I;
            PADDLE_TWO_ADDR:   s_d.rdata = PADDLE2_I;
            OSC3_READ_ADDR:    s_d.rdata = s_q.wave[11:4];
            ENV3_READ_ADDR:    s_d.rdata = s_q.level;
            default:           s_d.rdata = 8'h00;
         endcase
      end

      // Oscillator: phase accumulator advanced by the frequency word
      acc_sum   = {1'b0, s_q.acc} + {9'h000, s_q.freq};
      s_d.acc   = acc_sum[23:0];
      s_d.wrap  = ~s_q.acc[23] & acc_sum[23];
      if (s_q.ctrl[CTL_SYNC_BIT] && OSC2_WRAP_I) begin
         s_d.acc  = 24'h000000;
         s_d.wrap = 1'b0;
      end
      if (s_q.ctrl[CTL_TEST_BIT]) begin
         // Held at zero, noise reseeded, until the bit clears
         s_d.acc  = 24'h000000;
         s_d.wrap = 1'b0;
         s_d.lfsr = LFSR_RESET;
      end

      // Noise register shifts on each rise of accumulator bit 19
      s_d.clk19 = s_q.acc[19];
      if (!s_q.ctrl[CTL_TEST_BIT] && s_q.acc[19] && !s_q.clk19) begin
         s_d.lfsr = {s_q.lfsr[21:0], s_q.lfsr[22] ^ s_q.lfsr[17]};
      end

      s_d.wave = mix_w;

      // Envelope generator
      s_d.gate_prev = s_q.ctrl[CTL_GATE_BIT];
      s_d.step_cnt  = step ? 16'h0000 : s_q.step_cnt + 16'h0001;
      if (s_q.ctrl[CTL_GATE_BIT] && !s_q.gate_prev) begin
         s_d.env      = ENV_ATTACK;
         s_d.step_cnt = 16'h0000;
      end else if (!s_q.ctrl[CTL_GATE_BIT] && s_q.gate_prev) begin
         s_d.env      = ENV_RELEASE;
         s_d.step_cnt = 16'h0000;
      end else if (step) begin
         unique case (s_q.env)
            ENV_ATTACK: begin
               if (s_q.level == 8'hfe || s_q.level == 8'hff) begin
                  s_d.level = 8'hff;
                  s_d.env   = ENV_DECAY;
               end else begin
                  s_d.level = s_q.level + 8'h01;
               end
            end
            ENV_DECAY: begin
               // Falls to the sustain level and holds while gated
               if (s_q.level > sustain) begin
                  s_d.level = s_q.level - 8'h01;
               end
            end
            ENV_RELEASE: begin
               if (s_q.level != 8'h00) begin
                  s_d.level = s_q.level - 8'h01;
               end
            end
            default: begin
               s_d.env = ENV_RELEASE;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RSTN_I) begin
         s_q.freq      <= {REG_RESET, REG_RESET};
         s_q.pw        <= {REG_RESET[3:0], REG_RESET};
         s_q.ctrl      <= REG_RESET;
         s_q.ad        <= REG_RESET;
         s_q.sr        <= REG_RESET;
         s_q.cut_lo    <= REG_RESET[2:0];
         s_q.cut_hi    <= REG_RESET;
         s_q.res_rt    <= REG_RESET;
         s_q.mode_vol  <= REG_RESET;
         s_q.rdata     <= 8'h00;
         s_q.acc       <= 24'h000000;
         s_q.wrap      <= 1'b0;
         s_q.clk19     <= 1'b0;
         s_q.lfsr      <= LFSR_RESET;
         s_q.wave      <= 12'h000;
         s_q.env       <= ENV_RELEASE;
         s_q.level     <= 8'h00;
         s_q.step_cnt  <= 16'h0000;
         s_q.gate_prev <= 1'b0;
      end else if (CE_I) begin
         s_q <= s_d;
      end
   end

   // All outputs come straight from the state register
   assign RDATA_O        = s_q.rdata;
   assign FREQ_O         = s_q.freq;
   assign PULSE_WIDTH_O  = s_q.pw;
   assign WAVE_SEL_O     = s_q.ctrl[7:4];
   assign GATE_O         = s_q.ctrl[CTL_GATE_BIT];
   assign WAVE_O         = s_q.wave;
   assign OSC3_MSB_O     = s_q.acc[23];
   assign OSC3_WRAP_O    = s_q.wrap;
   assign ENV_LEVEL_O    = s_q.level;
   assign CUTOFF_O       = {s_q.cut_hi, s_q.cut_lo};
   assign RESONANCE_O    = s_q.res_rt[7:4];
   assign FILTER_ROUTE_O = s_q.res_rt[3:0];
   assign VOICE3_OFF_O   = s_q.mode_vol[MV_V3OFF_BIT];
   assign FILTER_MODE_O  = s_q.mode_vol[MV_HP_BIT:MV_LP_BIT];
   assign VOLUME_O       = s_q.mode_vol[3:0];

endmodule

// File: tb/voice3_filter_regs_chk.sv
// Port-level checks for the voice-3 and filter register bank.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module voice3_filter_regs_chk
   import voice3_pkg::*;
(
   input wire logic        REF_CLK_I,
   input wire logic        RSTN_I,
   input wire logic        CE_I,
   input wire logic [15:0] ADDR_I,
   input wire logic [7:0]  WDATA_I,
   input wire logic        WR_I,
   input wire logic        RD_I,
   input wire logic [7:0]  RDATA_O,
   input wire logic [7:0]  PADDLE1_I,
   input wire logic [11:0] PULSE_WIDTH_O,
   input wire logic [3:0]  WAVE_SEL_O,
   input wire logic        GATE_O,
   input wire logic        OSC3_MSB_O,
   input wire logic        OSC3_WRAP_O,
   input wire logic [7:0]  ENV_LEVEL_O,
   input wire logic [10:0] CUTOFF_O,
   input wire logic [3:0]  VOLUME_O
);
   default clocking @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RSTN_I);
   sequence wr_at(logic [15:0] a);
      CE_I && WR_I && ADDR_I == a;
   endsequence
   sequence rd_at(logic [15:0] a);
      CE_I && RD_I && ADDR_I == a;
   endsequence
   // Accumulator clears at the enabled edge after the bit lands; a later write cannot undo that
   sequence test_held;
      wr_at(CONTROL_ADDR) ##0 WDATA_I[CTL_TEST_BIT] ##1 CE_I;
   endsequence
   ctl_write_a: assert property (wr_at(CONTROL_ADDR) |=>
      WAVE_SEL_O == $past(WDATA_I[7:4]) && GATE_O == $past(WDATA_I[0])) else $error("control bits not applied");
   pw_high_a: assert property (wr_at(PW_HIGH_ADDR) |=>
      PULSE_WIDTH_O[11:8] == $past(WDATA_I[3:0])) else $error("pulse width high nibble wrong");
   cutoff_low_a: assert property (wr_at(CUTOFF_LOW_ADDR) |=>
      CUTOFF_O[2:0] == $past(WDATA_I[2:0])) else $error("cutoff low bits wrong");
   volume_set_a: assert property (wr_at(MODE_VOL_ADDR) |=>
      VOLUME_O == $past(WDATA_I[3:0])) else $error("volume not applied");
   paddle_read_a: assert property (rd_at(PADDLE_ONE_ADDR) |=>
      RDATA_O == $past(PADDLE1_I)) else $error("paddle read wrong");
   env_read_a: assert property (rd_at(ENV3_READ_ADDR) |=>
      RDATA_O == $past(ENV_LEVEL_O)) else $error("envelope read wrong");
   pw_unused_a: assert property (rd_at(PW_HIGH_ADDR) |=>
      RDATA_O[7:4] == 4'h0) else $error("unused pulse bits read nonzero");
   test_hold_a: assert property (test_held |=>
      !OSC3_MSB_O) else $error("oscillator runs with test bit set");
   rdata_idle_a: assert property (CE_I && !RD_I |=>
      RDATA_O == 8'h00) else $error("read data not cleared");
   wrap_rise_a: assert property (CE_I |=>
      OSC3_WRAP_O == $rose(OSC3_MSB_O)) else $error("wrap pulse does not match accumulator rise");
endmodule
bind voice3_filter_regs voice3_filter_regs_chk i_chk (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .CE_I(CE_I),
   .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .PADDLE1_I(PADDLE1_I),
   .PULSE_WIDTH_O(PULSE_WIDTH_O), .WAVE_SEL_O(WAVE_SEL_O), .GATE_O(GATE_O), .OSC3_MSB_O(OSC3_MSB_O),
   .OSC3_WRAP_O(OSC3_WRAP_O), .ENV_LEVEL_O(ENV_LEVEL_O), .CUTOFF_O(CUTOFF_O), .VOLUME_O(VOLUME_O));

// File: tb/voice3_host.sv
// Host processor model: byte-wide register master for the bank.
// Assumes the bench calls wr and rd hierarchically after reset.
`timescale 1ns/1ps
module voice3_host (
   input  wire logic        clk_i,
   output logic      [15:0] addr_o,
   output logic      [7:0]  wdata_o,
   output logic             wr_o,
   output logic             rd_o,
   input  wire logic [7:0]  rdata_i
);
   initial begin
      addr_o = 16'h0;
      wdata_o = 8'h0;
      wr_o = 1'h0;
      rd_o = 1'h0;
   end
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'h1;
      @(posedge clk_i);
      wr_o    <= 1'h0;
      // Released data shows its inverse so a stale byte never looks valid
      wdata_o <= ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'h1;
      @(posedge clk_i);
      rd_o <= 1'h0;
      @(negedge clk_i);
      d = rdata_i;
   endtask
endmodule

// File: tb/voice3_filter_regs_test.sv
// Bench for the voice-3 and filter register bank, driven through the host model.
// Assumes a step base of one cycle so an envelope sweep takes a few hundred cycles.
`timescale 1ns/1ps
module voice3_filter_regs_test;
   import voice3_pkg::*;
   logic        clk = 1'h0, rstn = 1'h0, msb2 = 1'h0, wrap2 = 1'h0, ce = 1'h1, wr, rd, gate, off;
   logic [7:0]  pad = 8'h5a, rdata, wdata, env, r1, r2, v;
   logic [15:0] addr, freq, a;
   logic [11:0] pw, wave, t0;
   logic [10:0] cut;
   logic [3:0]  wsel, res, route, vol;
   logic [2:0]  mode;
   logic [7:0]  wv [11] = '{8'h34, 8'h12, 8'hcd, 8'hab, 8'hf0, 8'h5a, 8'h7c, 8'hff, 8'h9e, 8'h6b, 8'hd5};
   int          n_fail = 0, tests_run = 0;
   always #50 clk = ~clk;
   voice3_host i_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
   voice3_filter_regs #(.ENV_BASE(1)) i_dut (.REF_CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PADDLE1_I(pad), .PADDLE2_I(~pad),
      .OSC2_MSB_I(msb2), .OSC2_WRAP_I(wrap2), .FREQ_O(freq), .PULSE_WIDTH_O(pw), .WAVE_SEL_O(wsel),
      .GATE_O(gate), .WAVE_O(wave), .OSC3_MSB_O(), .OSC3_WRAP_O(), .ENV_LEVEL_O(env), .CUTOFF_O(cut),
      .RESONANCE_O(res), .FILTER_ROUTE_O(route), .VOICE3_OFF_O(off), .FILTER_MODE_O(mode), .VOLUME_O(vol));
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
      end
   endtask
   task automatic rchk(input logic [15:0] ra, input logic [7:0] e);
      i_host.rd(ra, r1);
      chk(16'(r1), 16'(e));
   endtask
   task automatic wait_env(input logic [7:0] lv);
      for (int n = 0; n < 400 && env !== lv; n++)
         @(negedge clk);
      chk(16'(env), 16'(lv));
   endtask
   task automatic complete_run;
      if (n_fail == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #1ms;
      n_fail++;
      complete_run;
   end
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'h1;
      // Pass 2 reads reset values, pass 1 writes inverted bytes to catch stuck bits
      for (int p = 2; p >= 0; p--)
         for (int i = 0; i < 11; i++) begin
            a = FREQ_LOW_ADDR + 16'(i);
            v = p == 2 ? REG_RESET : p == 1 ? ~wv[i] : wv[i];
            if (p < 2)
               i_host.wr(a, v);
            rchk(a, v & (a == PW_HIGH_ADDR ? 8'h0f : a == CUTOFF_LOW_ADDR ? 8'h07 : 8'hff));
         end
      chk(freq, 16'h1234);
      chk(16'(pw), 16'h0bcd);
      chk(16'({wsel, gate}), 16'h001e);
      chk(16'(cut), 16'h04f7);
      chk(16'({res, route}), 16'h006b);
      chk(16'({off, mode, vol}), 16'h00d5);
      i_host.wr(PADDLE_ONE_ADDR, 8'h00);
      rchk(PADDLE_ONE_ADDR, 8'h5a);
      @(posedge clk) pad <= 8'h00;
      rchk(PADDLE_TWO_ADDR, 8'hff);
      rchk(16'hd41d, 8'h00);
      i_host.wr(CONTROL_ADDR, 8'h28);
      i_host.wr(FREQ_LOW_ADDR, 8'hff);
      i_host.wr(FREQ_HIGH_ADDR, 8'hff);
      chk(16'(wave), 16'h0000);
      rchk(OSC3_READ_ADDR, 8'h00);
      i_host.wr(CONTROL_ADDR, 8'h20);
      // Long enough for the accumulator top bit to rise and pulse the wrap output
      repeat (140) @(negedge clk);
      chk(16'(wave == 12'h0), 16'h0000);
      // Enable low freezes the running oscillator and drops a write
      @(posedge clk) ce <= 1'h0;
      i_host.wr(MODE_VOL_ADDR, 8'h00);
      t0 = wave;
      repeat (3) @(negedge clk);
      chk({wave, vol}, {t0, 4'h5});
      @(posedge clk) ce <= 1'h1;
      i_host.rd(OSC3_READ_ADDR, r2);
      rchk(16'hd40d, 8'h00);
      i_host.rd(OSC3_READ_ADDR, r1);
      chk(16'(r1 == r2), 16'h0000);
      i_host.wr(CONTROL_ADDR, 8'h22);
      @(posedge clk) wrap2 <= 1'h1;
      @(posedge clk) wrap2 <= 1'h0;
      repeat (3) @(negedge clk);
      chk(16'(wave[11:8]), 16'h0000);
      // Zero frequency freezes the accumulator so only the ring input moves the wave
      i_host.wr(CONTROL_ADDR, 8'h10);
      i_host.wr(FREQ_HIGH_ADDR, 8'h00);
      i_host.wr(FREQ_LOW_ADDR, 8'h00);
      repeat (3) @(negedge clk);
      t0 = wave;
      @(posedge clk) msb2 <= 1'h1;
      repeat (3) @(negedge clk);
      chk(16'(wave), 16'(t0));
      i_host.wr(CONTROL_ADDR, 8'h14);
      repeat (3) @(negedge clk);
      t0 = wave;
      @(posedge clk) msb2 <= 1'h0;
      repeat (3) @(negedge clk);
      chk(16'(wave == t0), 16'h0000);
      i_host.wr(PW_LOW_ADDR, 8'h00);
      i_host.wr(PW_HIGH_ADDR, 8'h00);
      i_host.wr(CONTROL_ADDR, 8'h40);
      repeat (3) @(negedge clk);
      t0 = wave;
      i_host.wr(PW_LOW_ADDR, 8'hff);
      i_host.wr(PW_HIGH_ADDR, 8'h0f);
      repeat (3) @(negedge clk);
      chk(16'(wave ^ t0), 16'h0fff);
      i_host.wr(CONTROL_ADDR, 8'h80);
      repeat (3) @(negedge clk);
      chk(16'(wave == 12'h0), 16'h0000);
      i_host.wr(ATTACK_DECAY_ADDR, 8'hf0);
      i_host.wr(SUST_REL_ADDR, 8'h80);
      i_host.wr(CONTROL_ADDR, 8'h01);
      repeat (100) @(negedge clk);
      chk(16'(env inside {[8'h01:8'h0f]}), 16'h0001);
      i_host.wr(CONTROL_ADDR, 8'h00);
      wait_env(8'h00);
      i_host.wr(ATTACK_DECAY_ADDR, 8'h00);
      i_host.wr(CONTROL_ADDR, 8'h01);
      wait_env(8'hff);
      wait_env(8'h88);
      repeat (20) @(negedge clk);
      rchk(ENV3_READ_ADDR, 8'h88);
      i_host.wr(CONTROL_ADDR, 8'h00);
      wait_env(8'h00);
      complete_run;
   end
endmodule
